// *** aic_pkg.sv ***
package aic_pkg;

	// ------------------------------------------------------------
	// channel count and data widths
	// ------------------------------------------------------------
	localparam int unsigned AIC_NCH       = 3;
	localparam int unsigned AIC_RAW_W     = 12;
	localparam int unsigned AIC_PCT_W     = 12;
	localparam int unsigned AIC_SPD_W     = 16;

	// percent values are in tenths of a percent
	localparam logic signed [AIC_PCT_W-1:0] AIC_PCT_MAX   = 12'sd1000;
	localparam logic signed [AIC_PCT_W-1:0] AIC_PCT_MIN   = -12'sd1000;
	localparam logic [13:0]                 AIC_GAIN_MAX  = 14'd9999;
	localparam logic [13:0]                 AIC_GAIN_RST  = 14'd1000;
	localparam logic signed [AIC_PCT_W-1:0] AIC_OFS_RST   = 12'sd0;
	localparam logic [10:0]                 AIC_FILT_MAX  = 11'd1600;
	localparam logic [10:0]                 AIC_FILT_RST  = 11'd0;

	// ------------------------------------------------------------
	// converter code scaling
	// ------------------------------------------------------------
	localparam int AIC_LIVE_ZERO_CODE = 819;
	localparam int AIC_MID_CODE       = 2048;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned AIC_CLK_HZ        = 100_000_000;
	localparam int unsigned AIC_TICK_US       = 125;
	localparam int unsigned AIC_TICK_CYC      = AIC_CLK_HZ / 1_000_000 * AIC_TICK_US;
	// filter time constant unit 10 ms = 16 updates of 625 us = 5 ticks
	localparam logic [2:0]  AIC_TICKS_PER_UNIT = 3'd5;

	// ------------------------------------------------------------
	// modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		AIC_FN_SPEED    = 4'h0,
		AIC_FN_UNUSED1  = 4'h1,
		AIC_FN_TORQUE   = 4'h2,
		AIC_FN_USER     = 4'h3,
		AIC_FN_THERM    = 4'h4,
		AIC_FN_PID1     = 4'h5,
		AIC_FN_PID2     = 4'h6,
		AIC_FN_UNUSED7  = 4'h7,
		AIC_FN_EXT_PID  = 4'h8
	} aic_func_e;

	typedef enum logic [2:0] {
		AIC_SIG_DIRECT   = 3'h0,
		AIC_SIG_LIVE     = 3'h1,
		AIC_SIG_INV      = 3'h2,
		AIC_SIG_INV_LIVE = 3'h3,
		AIC_SIG_BIPOLAR  = 3'h4
	} aic_sig_e;

	// ------------------------------------------------------------
	// register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] AIC_REG_CTRL    = 8'h00;
	localparam logic [7:0] AIC_REG_MIN_SPD = 8'h04;
	localparam logic [7:0] AIC_REG_MAX_SPD = 8'h08;
	localparam logic [7:0] AIC_REG_ACC     = 8'h0c;
	localparam logic [7:0] AIC_REG_DEC     = 8'h10;
	localparam logic [7:0] AIC_REG_CH_BASE = 8'h20;
	localparam logic [7:0] AIC_REG_CH_STEP = 8'h10;
	localparam logic [7:0] AIC_CH_CFG      = 8'h0;
	localparam logic [7:0] AIC_CH_GAIN     = 8'h4;
	localparam logic [7:0] AIC_CH_OFS      = 8'h8;
	localparam logic [7:0] AIC_CH_FILT     = 8'hc;
	localparam logic [7:0] AIC_REG_RD_BASE = 8'h50;
	localparam logic [7:0] AIC_REG_STATUS  = 8'h5c;

	// control register fields
	localparam int AIC_CTRL_DZ     = 0;
	localparam int AIC_CTRL_REMOTE = 1;
	localparam int AIC_CTRL_LSRC   = 4;
	localparam int AIC_CTRL_RSRC   = 8;
	// channel config fields
	localparam int AIC_CFG_FN      = 0;
	localparam int AIC_CFG_SIG     = 4;

	localparam logic [AIC_SPD_W-1:0] AIC_MIN_SPD_RST = 16'h0000;
	localparam logic [AIC_SPD_W-1:0] AIC_MAX_SPD_RST = 16'h0708;
	localparam logic [AIC_SPD_W-1:0] AIC_STEP_RST    = 16'h0001;

endpackage

// *** aic_chan.sv ***
`timescale 1ns/1ps
module aic_chan (
	// clock and reset
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// converter sample
	input  wire logic [aic_pkg::AIC_RAW_W-1:0]        sample,
	input  wire logic                                 sample_valid,
	input  wire logic                                 tick,
	// settings
	input  wire logic [2:0]                           sig_type,
	input  wire logic signed [aic_pkg::AIC_PCT_W-1:0] offset,
	input  wire logic [13:0]                          gain,
	input  wire logic [10:0]                          filt,
	// conditioned value
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      value_r
);
	import aic_pkg::*;

	// ------------------------------------------------------------
	// scaling, offset, gain, inversion, saturation
	// ------------------------------------------------------------
	logic signed [31:0]          frac;
	logic signed [31:0]          d;
	logic signed [31:0]          scaled;
	logic signed [AIC_PCT_W-1:0] sat;
	logic signed [AIC_PCT_W-1:0] cond_r;

	always_comb begin
		d = 32'sd0;
		case (sig_type)
			AIC_SIG_LIVE, AIC_SIG_INV_LIVE: begin
				d = $signed({20'h0, sample}) - AIC_LIVE_ZERO_CODE;
				frac = (d < 0) ? 32'sd0 : ((d * 5000) >>> 14); // [R13]
				if (frac > 32'sd1000)
					frac = 32'sd1000;
			end
			AIC_SIG_BIPOLAR: begin
				d = $signed({20'h0, sample}) - AIC_MID_CODE;
				frac = (d * 1000) >>> 11; // [R5]
			end
			default: begin
				frac = ($signed({20'h0, sample}) * 1000) >>> 12; // [R13]
			end
		endcase
		// offset before gain, gain in thousandths
		scaled = ((frac + 32'(offset)) * $signed({18'h0, gain})) / 1000; // [R12] [R13]
		if (sig_type == AIC_SIG_INV || sig_type == AIC_SIG_INV_LIVE)
			scaled = 32'sd1000 - scaled; // [R14]
		if (scaled > 32'sd1000)
			sat = AIC_PCT_MAX; // [R16]
		else if (scaled < -32'sd1000)
			sat = AIC_PCT_MIN; // [R16]
		else
			sat = scaled[AIC_PCT_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cond_r <= '0;
		else if (sample_valid)
			cond_r <= sat;
	end

	// ------------------------------------------------------------
	// first-order low pass: 16 steps of 1/16 per time constant
	// ------------------------------------------------------------
	logic signed [15:0] acc_r;
	logic [13:0]        cnt_r;
	logic [13:0]        period;
	logic signed [15:0] target;

	assign period = 14'(filt * AIC_TICKS_PER_UNIT);
	assign target = 16'(cond_r) <<< 4;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= '0;
			cnt_r <= '0;
		end else if (filt == '0) begin
			acc_r <= target; // [R12]
			cnt_r <= '0;
		end else if (tick) begin
			if (cnt_r + 14'd1 >= period) begin
				cnt_r <= '0;
				acc_r <= acc_r + ((target - acc_r) >>> 4); // [R15]
			end else begin
				cnt_r <= cnt_r + 14'd1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			value_r <= '0;
		else
			value_r <= AIC_PCT_W'(acc_r >>> 4);
	end

endmodule

// *** aic_main.sv ***
// Summary of operation
// R1: each channel readout shows percent after offset and gain, -100 to +100.
// R2: dead zone applies only to channels used as speed reference.
// R3: dead zone off: minimum input maps straight to minimum speed.
// R4: dead zone on: reference stays at minimum speed over an initial input band.
// R5: third channel bipolar type 4: negative input reverses rotation.
// R6: function codes 0 speed,2 torque,3 user,4 thermistor,5/6 pid,8 ext pid.
// R7: speed reference limited by min/max, ramped, used only when source names channel.
// R8: function 4 routes channel to motor thermistor monitoring.
// R9: function 3 feeds only the user program area.
// R10: gain 0.000 to 9.999 in thousandths, reset 1.000.
// R11: offset -100.0 to +100.0 percent in tenths, reset 0.0.
// R12: order scaling, offset, gain, filter, dispatch; filter 0 to 16.00 s.
// R13: percent is scaled fraction times 100 plus offset, times gain.
// R14: signal types 2 and 3 invert: 100 percent minus result.
// R15: filter is first-order low pass with the set time constant.
// R16: conditioned value saturates to plus or minus 100.0 percent.
`timescale 1ns/1ps
module aic_main #(
	parameter int unsigned TICK_CYC = aic_pkg::AIC_TICK_CYC
) (
	// clock and reset
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	// apb slave
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [7:0]                           paddr,
	input  wire logic [31:0]                          pwdata,
	output logic [31:0]                               prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	// converter samples
	input  wire logic [aic_pkg::AIC_RAW_W-1:0]        sample_ch0,
	input  wire logic [aic_pkg::AIC_RAW_W-1:0]        sample_ch1,
	input  wire logic [aic_pkg::AIC_RAW_W-1:0]        sample_ch2,
	input  wire logic                                 sample_valid,
	// speed reference to the drive
	output logic signed [aic_pkg::AIC_SPD_W:0]        speed_ref,
	output logic                                      speed_ref_valid,
	output logic                                      reverse,
	// other functions
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      torque_limit,
	output logic                                      torque_limit_valid,
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      thermistor_level,
	output logic                                      thermistor_valid,
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      user_value,
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      pid_feedback1,
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      pid_feedback2,
	output logic signed [aic_pkg::AIC_PCT_W-1:0]      ext_pid_feedback
);
	import aic_pkg::*;

	// ------------------------------------------------------------
	// settings
	// ------------------------------------------------------------
	logic                        dead_zone_select_r;
	logic                        remote_active_r;
	logic [1:0]                  local_reference_source_r;
	logic [1:0]                  remote_reference_source_r;
	logic [AIC_SPD_W-1:0]        minimum_speed_limit_r;
	logic [AIC_SPD_W-1:0]        maximum_speed_limit_r;
	logic [AIC_SPD_W-1:0]        accel_step_r;
	logic [AIC_SPD_W-1:0]        decel_step_r;
	logic [3:0]                  func_r   [AIC_NCH];
	logic [2:0]                  sig_r    [AIC_NCH];
	logic [13:0]                 gain_r   [AIC_NCH];
	logic signed [AIC_PCT_W-1:0] offset_r [AIC_NCH];
	logic [10:0]                 filt_r   [AIC_NCH];
	logic signed [AIC_PCT_W-1:0] chan_val [AIC_NCH];
	logic [AIC_RAW_W-1:0]        samples  [AIC_NCH];

	assign samples[0] = sample_ch0;
	assign samples[1] = sample_ch1;
	assign samples[2] = sample_ch2;

	// ------------------------------------------------------------
	// filter tick
	// ------------------------------------------------------------
	logic [15:0] tick_cnt_r;
	logic        tick_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r >= 16'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'd1;
			tick_r     <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// conditioning channels
	// ------------------------------------------------------------
	for (genvar c = 0; c < AIC_NCH; c++) begin : g_ch
		aic_chan u_chan (
			.pclk         (pclk),
			.presetn      (presetn),
			.sample       (samples[c]),
			.sample_valid (sample_valid),
			.tick         (tick_r),
			.sig_type     (sig_r[c]),
			.offset       (offset_r[c]),
			.gain         (gain_r[c]),
			.filt         (filt_r[c]),
			.value_r      (chan_val[c])
		);
	end

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// registered answer in setup phase gives zero wait states
	logic        setup;
	logic        wr_en;
	logic        hit;
	logic [31:0] rd_val;
	logic [1:0]  ch_idx;
	logic [7:0]  ch_ofs;
	logic        ch_hit;
	logic        rd_hit;
	logic signed [AIC_SPD_W:0] ramp_r;

	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite && !pslverr;

	always_comb begin
		ch_idx = 2'd0;
		ch_ofs = paddr - AIC_REG_CH_BASE;
		ch_hit = 1'b0;
		rd_hit = 1'b0;
		if (paddr >= AIC_REG_CH_BASE && paddr < AIC_REG_RD_BASE) begin
			ch_idx = 2'(ch_ofs >> 4);
			ch_ofs = ch_ofs & 8'h0c;
			ch_hit = 1'b1;
		end else if (paddr >= AIC_REG_RD_BASE && paddr < AIC_REG_STATUS) begin
			ch_idx = 2'((paddr - AIC_REG_RD_BASE) >> 2);
			rd_hit = 1'b1;
		end
	end

	always_comb begin
		hit    = (paddr[1:0] == 2'b00);
		rd_val = 32'h0;
		if (ch_hit) begin
			case (ch_ofs)
				AIC_CH_CFG:  rd_val = {25'h0, sig_r[ch_idx], func_r[ch_idx]};
				AIC_CH_GAIN: rd_val = {18'h0, gain_r[ch_idx]};
				AIC_CH_OFS:  rd_val = 32'(offset_r[ch_idx]);
				default:     rd_val = {21'h0, filt_r[ch_idx]};
			endcase
		end else if (rd_hit) begin
			rd_val = 32'(chan_val[ch_idx]); // [R1]
		end else begin
			case (paddr)
				AIC_REG_CTRL:    rd_val = {22'h0, remote_reference_source_r, 2'h0,
					local_reference_source_r, 2'h0, remote_active_r, dead_zone_select_r};
				AIC_REG_MIN_SPD: rd_val = {16'h0, minimum_speed_limit_r};
				AIC_REG_MAX_SPD: rd_val = {16'h0, maximum_speed_limit_r};
				AIC_REG_ACC:     rd_val = {16'h0, accel_step_r};
				AIC_REG_DEC:     rd_val = {16'h0, decel_step_r};
				AIC_REG_STATUS:  rd_val = {14'h0, reverse, 17'(ramp_r)};
				default:         hit = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= (pwrite || !hit) ? 32'h0 : rd_val;
			pready  <= 1'b1;
			pslverr <= !hit;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	logic signed [31:0] wofs;
	assign wofs = $signed(pwdata);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dead_zone_select_r        <= 1'b0;
			remote_active_r           <= 1'b0;
			local_reference_source_r  <= '0;
			remote_reference_source_r <= '0;
			minimum_speed_limit_r     <= AIC_MIN_SPD_RST;
			maximum_speed_limit_r     <= AIC_MAX_SPD_RST;
			accel_step_r              <= AIC_STEP_RST;
			decel_step_r              <= AIC_STEP_RST;
		end else if (wr_en && !ch_hit) begin
			case (paddr)
				AIC_REG_CTRL: begin
					dead_zone_select_r        <= pwdata[AIC_CTRL_DZ];
					remote_active_r           <= pwdata[AIC_CTRL_REMOTE];
					local_reference_source_r  <= pwdata[AIC_CTRL_LSRC +: 2];
					remote_reference_source_r <= pwdata[AIC_CTRL_RSRC +: 2];
				end
				AIC_REG_MIN_SPD: minimum_speed_limit_r <= pwdata[AIC_SPD_W-1:0];
				AIC_REG_MAX_SPD: maximum_speed_limit_r <= pwdata[AIC_SPD_W-1:0];
				AIC_REG_ACC:     accel_step_r          <= pwdata[AIC_SPD_W-1:0];
				AIC_REG_DEC:     decel_step_r          <= pwdata[AIC_SPD_W-1:0];
				default: ;
			endcase
		end
	end

	// out-of-range gain, offset and filter values are clamped to the legal span
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < AIC_NCH; i++) begin
				func_r[i]   <= AIC_FN_SPEED; // [R6]
				sig_r[i]    <= AIC_SIG_DIRECT;
				gain_r[i]   <= AIC_GAIN_RST; // [R10]
				offset_r[i] <= AIC_OFS_RST; // [R11]
				filt_r[i]   <= AIC_FILT_RST; // [R12]
			end
		end else if (wr_en && ch_hit && ch_idx < 2'(AIC_NCH)) begin
			case (ch_ofs)
				AIC_CH_CFG: begin
					func_r[ch_idx] <= pwdata[AIC_CFG_FN +: 4];
					// bipolar range exists only on the third channel
					if (pwdata[AIC_CFG_SIG +: 3] <= 3'(AIC_SIG_INV_LIVE) ||
						(pwdata[AIC_CFG_SIG +: 3] == AIC_SIG_BIPOLAR && ch_idx == 2'd2))
						sig_r[ch_idx] <= pwdata[AIC_CFG_SIG +: 3]; // [R5]
				end
				AIC_CH_GAIN:
					gain_r[ch_idx] <= (pwdata > 32'(AIC_GAIN_MAX)) ?
						AIC_GAIN_MAX : pwdata[13:0]; // [R10]
				AIC_CH_OFS:
					offset_r[ch_idx] <= (wofs > 32'(AIC_PCT_MAX)) ? AIC_PCT_MAX :
						(wofs < 32'(AIC_PCT_MIN)) ? AIC_PCT_MIN : pwdata[AIC_PCT_W-1:0]; // [R11]
				default:
					filt_r[ch_idx] <= (pwdata > 32'(AIC_FILT_MAX)) ?
						AIC_FILT_MAX : pwdata[10:0]; // [R12]
			endcase
		end
	end

	// ------------------------------------------------------------
	// speed reference from the selected channel
	// ------------------------------------------------------------
	logic [1:0]                  src;
	logic                        src_ok;
	logic signed [AIC_PCT_W-1:0] src_val;
	logic [31:0]                 mag;
	logic [31:0]                 span;
	logic [31:0]                 spd;
	logic signed [AIC_SPD_W:0]   target;

	always_comb begin
		src     = remote_active_r ? remote_reference_source_r : local_reference_source_r;
		src_ok  = (src != 2'd0) && (func_r[src - 2'd1] == AIC_FN_SPEED); // [R7]
		src_val = chan_val[src - 2'd1];
		mag     = (src_val < 0) ? 32'(-src_val) : 32'(src_val);
		span    = (maximum_speed_limit_r > minimum_speed_limit_r) ?
			32'(maximum_speed_limit_r - minimum_speed_limit_r) : 32'h0;
		if (dead_zone_select_r) begin
			// linear from zero, held at minimum below it
			spd = (mag * 32'(maximum_speed_limit_r)) / 1000; // [R2] [R4]
			if (spd < 32'(minimum_speed_limit_r))
				spd = 32'(minimum_speed_limit_r); // [R4]
		end else begin
			spd = 32'(minimum_speed_limit_r) + (mag * span) / 1000; // [R3]
		end
		if (spd > 32'(maximum_speed_limit_r))
			spd = 32'(maximum_speed_limit_r); // [R7]
		if (!src_ok)
			target = '0;
		else if (src_val < 0)
			target = -$signed({1'b0, spd[AIC_SPD_W-1:0]}); // [R5]
		else
			target = $signed({1'b0, spd[AIC_SPD_W-1:0]});
	end

	// ------------------------------------------------------------
	// acceleration and deceleration ramp
	// ------------------------------------------------------------
	logic signed [AIC_SPD_W+1:0] diff;
	logic signed [AIC_SPD_W+1:0] step;
	logic                        away;

	always_comb begin
		diff = 18'(target) - 18'(ramp_r);
		// moving away from standstill accelerates, toward it decelerates
		away = (ramp_r == '0) ? 1'b1 : ((diff > 0) == (ramp_r > 0));
		step = away ? $signed({2'b00, accel_step_r}) : $signed({2'b00, decel_step_r});
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_r <= '0;
		end else if (tick_r) begin
			if (diff > step)
				ramp_r <= 17'(18'(ramp_r) + step); // [R7]
			else if (diff < -step)
				ramp_r <= 17'(18'(ramp_r) - step); // [R7]
			else
				ramp_r <= target;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_ref       <= '0;
			speed_ref_valid <= 1'b0;
			reverse         <= 1'b0;
		end else begin
			speed_ref       <= ramp_r;
			speed_ref_valid <= src_ok; // [R7]
			reverse         <= (ramp_r < 0); // [R5]
		end
	end

	// ------------------------------------------------------------
	// function dispatch, lowest channel wins on a tie
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			torque_limit       <= '0;
			torque_limit_valid <= 1'b0;
			thermistor_level   <= '0;
			thermistor_valid   <= 1'b0;
			user_value         <= '0;
			pid_feedback1      <= '0;
			pid_feedback2      <= '0;
			ext_pid_feedback   <= '0;
		end else begin
			torque_limit_valid <= 1'b0;
			thermistor_valid   <= 1'b0;
			for (int i = AIC_NCH - 1; i >= 0; i--) begin
				case (func_r[i])
					AIC_FN_TORQUE: begin
						torque_limit       <= chan_val[i]; // [R6]
						torque_limit_valid <= 1'b1;
					end
					AIC_FN_THERM: begin
						thermistor_level <= chan_val[i]; // [R8]
						thermistor_valid <= 1'b1;
					end
					AIC_FN_USER:    user_value       <= chan_val[i]; // [R9]
					AIC_FN_PID1:    pid_feedback1    <= chan_val[i]; // [R6]
					AIC_FN_PID2:    pid_feedback2    <= chan_val[i]; // [R6]
					AIC_FN_EXT_PID: ext_pid_feedback <= chan_val[i]; // [R6]
					default: ;
				endcase
			end
		end
	end

endmodule

// *** aic_adc_model.sv ***
`timescale 1ns/1ps
module aic_adc_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// terminal levels as codes
	input  wire logic [11:0] code0,
	input  wire logic [11:0] code1,
	input  wire logic [11:0] code2,
	// converted samples
	output logic [11:0]      sample_ch0,
	output logic [11:0]      sample_ch1,
	output logic [11:0]      sample_ch2,
	output logic             sample_valid
);
	logic [5:0] cnt_r;

	// samples only move with the strobe, so a late read never sees a torn set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 6'h00;
			sample_valid <= 1'b0;
			sample_ch0 <= 12'h000;
			sample_ch1 <= 12'h000;
			sample_ch2 <= 12'h000;
		end else begin
			cnt_r <= cnt_r + 6'h01;
			sample_valid <= (cnt_r == 6'h3f);
			if (cnt_r == 6'h3f) begin
				sample_ch0 <= code0;
				sample_ch1 <= code1;
				sample_ch2 <= code2;
			end
		end
	end
endmodule

// *** aic_main_chk.sv ***
`timescale 1ns/1ps
module aic_main_chk (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic [31:0]        prdata,
	input wire logic signed [16:0] speed_ref,
	input wire logic               reverse,
	input wire logic signed [11:0] torque_limit,
	input wire logic signed [11:0] thermistor_level,
	input wire logic signed [11:0] pid_feedback1
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	property p_rdy; s_setup |=> pready; endproperty
	property p_cause; pready |-> $past(psel && !penable); endproperty
	property p_once; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	property p_tq; torque_limit <= 12'sd1000 && torque_limit >= -12'sd1000; endproperty
	property p_th; thermistor_level <= 12'sd1000 && thermistor_level >= -12'sd1000; endproperty
	property p_pid; pid_feedback1 <= 12'sd1000 && pid_feedback1 >= -12'sd1000; endproperty
	property p_rev; speed_ref < 0 |-> ##[0:1] reverse; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready after setup");
	a_cause: assert property (p_cause) else $error("ready without setup");
	a_once: assert property (p_once) else $error("ready too long");
	a_err: assert property (p_err) else $error("error with data");
	a_tq: assert property (p_tq) else $error("torque out of range");
	a_th: assert property (p_th) else $error("thermistor out of range");
	a_pid: assert property (p_pid) else $error("feedback out of range");
	a_rev: assert property (p_rev) else $error("reverse missing");
endmodule
bind aic_main aic_main_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.speed_ref(speed_ref), .reverse(reverse), .torque_limit(torque_limit),
	.thermistor_level(thermistor_level), .pid_feedback1(pid_feedback1));

// *** aic_main_tb.sv ***
`timescale 1ns/1ps
module aic_main_tb;
	import aic_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rq, rs = 32'h10;
	logic pready, pslverr, re, sv, spd_v, rev, tq_v, th_v;
	logic [11:0] code0 = 12'h0, code1 = 12'h0, code2 = 12'h0, s0, s1, s2;
	logic signed [16:0] spd;
	logic signed [11:0] tq, th, usr, pid1, pid2, epid;
	int n_fail = 0, check_count = 0, cyc = 0;
	always #5 pclk = ~pclk;
	aic_adc_model adc (.pclk(pclk), .presetn(presetn), .code0(code0), .code1(code1),
		.code2(code2), .sample_ch0(s0), .sample_ch1(s1), .sample_ch2(s2), .sample_valid(sv));
	aic_main #(.TICK_CYC(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sample_ch0(s0), .sample_ch1(s1),
		.sample_ch2(s2), .sample_valid(sv), .speed_ref(spd), .speed_ref_valid(spd_v),
		.reverse(rev), .torque_limit(tq), .torque_limit_valid(tq_v), .thermistor_level(th),
		.thermistor_valid(th_v), .user_value(usr), .pid_feedback1(pid1),
		.pid_feedback2(pid2), .ext_pid_feedback(epid));
	function automatic logic [31:0] xs();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic logic [7:0] ca(int c, int r);
		return 8'(32 + 16 * c + r);
	endfunction
	function automatic int pct(int c, int t, int o, int g);
		int f;
		f = (t == 4) ? (c - 2048) * 1000 / 2048 : (t[0] ? (c - 819) * 5000 / 16384 : c * 1000 / 4096);
		if (t[0]) f = f < 0 ? 0 : (f > 1000 ? 1000 : f);
		f = (f + o) * g / 1000;
		if (t == 2 || t == 3) f = 1000 - f;
		return f < -1000 ? -1000 : (f > 1000 ? 1000 : f);
	endfunction
	function automatic logic [12:0] fo(int f);
		case (f)
			2: return {tq_v, tq};
			3: return {1'b1, usr};
			4: return {th_v, th};
			5: return {1'b1, pid1};
			6: return {1'b1, pid2};
			default: return {1'b1, epid};
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// speed check: e is the expected ramp target, sign gives direction
	task automatic spchk(input logic [31:0] ctl, input int e);
		apb(1, 8'h00, ctl);
		repeat (3000) @(posedge pclk);
		chk({spd_v, rev, spd}, {1'b1, e < 0, 17'(e)}, "speed");
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		int g, o, e;
		int fl[6] = '{2, 3, 4, 5, 6, 8};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int c = 0; c < 3; c++) begin
			apb(0, ca(c, 0), 0);
			chk(rq, 32'h0, "cfg");
			apb(0, ca(c, 4), 0);
			chk(rq, 32'd1000, "gain");
			apb(0, ca(c, 8), 0);
			chk(rq, 32'h0, "offset");
			apb(0, ca(c, 12), 0);
			chk(rq, 32'h0, "filter");
		end
		apb(0, 8'h90, 0);
		chk(re, 1'b1, "slverr");
		apb(0, 8'h25, 0);
		chk(re, 1'b1, "unaligned err");
		chk(rq, 32'h0, "unaligned data");
		$display("test defaults done");
		// signal type equals channel index, channel 0 also type 3
		apb(1, ca(1, 0), 32'h10);
		apb(1, ca(1, 0), 32'h41);
		apb(0, ca(1, 0), 0);
		chk(rq, 32'h11, "cfg keep");
		apb(1, ca(2, 0), 32'h20);
		code2 <= 12'd1024;
		for (int i = 0; i < 6; i++) begin
			g = xs() % 10000;
			o = xs() % 1001;
			code0 <= 12'(xs());
			code1 <= 12'(xs());
			apb(1, ca(0, 0), 48 * (~i & 1));
			for (int c = 0; c < 3; c++) begin
				apb(1, ca(c, 4), g);
				apb(1, ca(c, 8), o);
			end
			repeat (200) @(posedge pclk);
			for (int c = 0; c < 3; c++) begin
				e = pct(c == 0 ? code0 : (c == 1 ? code1 : code2),
					c == 0 ? 3 * (~i & 1) : c, o, g);
				apb(0, 8'(80 + 4 * c), 0);
				chk(rq[11:0], e[11:0], "readout");
			end
		end
		e = pct(code1, 1, o, g);
		apb(1, ca(1, 12), 1600);
		code1 <= code1 ^ 12'h800;
		repeat (200) @(posedge pclk);
		apb(0, 8'h54, 0);
		chk(rq[11:0], e[11:0], "filter hold");
		apb(1, ca(0, 4), 9999);
		apb(1, ca(0, 8), 1000);
		code0 <= 12'hfff;
		apb(1, ca(2, 0), 32'h40);
		apb(1, ca(2, 4), 1000);
		apb(1, ca(2, 8), 32'hffffff9c);
		repeat (200) @(posedge pclk);
		apb(0, 8'h50, 0);
		chk(rq[11:0], 12'd1000, "saturated");
		apb(0, 8'h58, 0);
		e = pct(1024, 4, -100, 1000);
		chk(rq[11:0], e[11:0], "bipolar");
		$display("test readouts done");
		apb(1, ca(0, 4), 1000);
		apb(1, ca(0, 8), 0);
		code0 <= 12'd2048;
		apb(1, 8'h00, 32'h1);
		foreach (fl[k]) begin
			apb(1, ca(0, 0), fl[k]);
			repeat (150) @(posedge pclk);
			chk(fo(fl[k]), 13'h11f4, "dispatch");
		end
		$display("test dispatch done");
		apb(1, ca(0, 0), 0);
		apb(1, 8'h0c, 32'h100);
		apb(1, 8'h10, 32'h100);
		spchk(32'h10, 900);
		apb(1, 8'h04, 300);
		code0 <= 12'd164;
		spchk(32'h10, 360);
		spchk(32'h11, 300);
		apb(1, ca(2, 8), 0);
		spchk(32'h30, -1050);
		spchk(32'h132, 360);
		$display("test speed done");
		test_done();
	end
endmodule
